// [rtl/pss_pkg.sv]
package pss_pkg;

  // Boot configuration page: one 2 KB flash page, read a word at a time
  localparam int unsigned BOOT_PAGE_BYTES = 2048;
  localparam int unsigned BOOT_WORD_BYTES = 4;
  localparam int unsigned BOOT_WORDS = BOOT_PAGE_BYTES / BOOT_WORD_BYTES;
  localparam int unsigned BOOT_AW = 9;
  localparam logic [BOOT_AW-1:0] BOOT_LAST_ADDR = 9'h1FF;
  // First half holds the hardware structure, second half the design parameters
  localparam logic [BOOT_AW-1:0] BOOT_HW_LAST_ADDR = 9'h0FF;
  localparam int unsigned IO_DIR_W = 32;
  localparam logic [BOOT_AW-1:0] BOOT_IO_DIR_ADDR = 9'h000;
  localparam logic [IO_DIR_W-1:0] IO_DIR_RESET = 32'h0000_0000;

  // Power-on reset stretch and boot sequence length
  localparam int unsigned POR_TIME_NS = 1000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] POR_LAST = 8'(POR_CYCLES - 1);
  localparam logic [CNT_W-1:0] BOOT_SEQ_LAST = 8'h0F;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // Nominal 32.768 kHz oscillator, kept running in every operating state
  localparam int unsigned SLOW_OSC_HZ = 32768;

  typedef enum logic [8:0] {
    PSS_POR     = 9'h001,
    PSS_LOAD    = 9'h002,
    PSS_CHECK   = 9'h004,
    PSS_FLASHEM = 9'h008,
    PSS_LOWPWR  = 9'h010,
    PSS_BOOT    = 9'h020,
    PSS_ACTIVE  = 9'h040,
    PSS_DOZE    = 9'h080,
    PSS_RFCHECK = 9'h100
  } pss_state_e;

  // Requests from peripherals and the CPU that keep the chip out of Doze
  typedef struct packed {
    logic cpu_busy;
    logic periph_busy;
    logic io_wake;
    logic timer_wake;
    logic rf_energy;
    logic packet_detected;
  } pss_activity_s;

  // Radio scheduler handshake
  typedef struct packed {
    logic start_req;
    logic busy;
  } pss_radio_in_s;

  typedef struct packed {
    logic relax_osc_en;
    logic slow_osc_en;
    logic slow_timer_en;
    logic periph_en;
    logic cpu_run;
    logic state_retain;
  } pss_power_s;

endpackage

// [rtl/pss_sequencer.sv]
`timescale 1ns/1ps
// How it works
// - Radio block request refuses new radio operations
// - Running radio operation finishes before inhibit applies
// - Forced doze holds Doze until negated
// - Power-on or reset pin starts start-up
// - Synchronised reset fall loads boot page, I/O direction
// - Programming enable plus reset enters flash emulation
// - Reset held without programming: minimum energy wait
// - Reset release boots then enters Active
// - Boot page 2 KB: hardware and design parts
// - Flash emulation acts as SPI serial flash
// - Operate CPU-active, CPU-inactive, Doze; lowest power
// - Active runs relaxation oscillator, peripherals as needed
// - Doze only when CPU, peripherals inactive, unless forced
// - Doze keeps state, wakes on I/O activity
// - Doze keeps 32.768 kHz oscillator, timers running
// - Peripherals move Active and Doze without CPU
// - Duty cycle checks RF, wakes CPU on packet
module pss_sequencer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_done,
  input wire logic reset_pin_n,
  input wire logic program_mode_enable_n,
  input wire logic radio_inhibit_n,
  input wire logic forced_doze_n,
  input wire logic time_capture_request_n,
  input wire logic uart_activity,
  input wire logic duty_cycle_en,
  input wire logic rf_check_due,
  input wire pss_pkg::pss_activity_s activity,
  input wire pss_pkg::pss_radio_in_s radio_in,
  input wire logic [pss_pkg::IO_DIR_W-1:0] boot_rdata,
  output logic [pss_pkg::BOOT_AW-1:0] boot_addr,
  output logic boot_rd,
  output logic [pss_pkg::IO_DIR_W-1:0] io_dir,
  output logic [pss_pkg::IO_DIR_W-1:0] design_cfg,
  output logic flash_emul_en,
  output logic min_energy,
  output logic radio_start_grant,
  output logic radio_inhibited,
  output logic cpu_wake,
  output logic operational,
  output pss_pkg::pss_power_s power,
  output pss_pkg::pss_state_e state
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    pss_pkg::pss_state_e st;
    logic [pss_pkg::CNT_W-1:0] cnt;
    logic [pss_pkg::BOOT_AW-1:0] addr;
    logic rd;
    logic rd_pend;
    logic [pss_pkg::IO_DIR_W-1:0] io_dir;
    logic [pss_pkg::IO_DIR_W-1:0] design_cfg;
    logic rst_d;
    logic radio_active;
    logic inhibited;
    logic grant;
    logic cpu_wake;
    logic flash_emul;
    logic min_energy;
    logic operational;
    pss_pkg::pss_power_s power;
  } pss_regs_s;

  pss_regs_s st_r;
  pss_regs_s st_nxt;

  logic rst_s_n;
  logic prog_s_n;
  logic inhibit_s_n;
  logic doze_s_n;
  logic time_s_n;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pss_sync u_sync_rst (
    .clk(clk),
    .rstn(rstn),
    .din(reset_pin_n),
    .dout(rst_s_n)
  );
  pss_sync u_sync_prog (
    .clk(clk),
    .rstn(rstn),
    .din(program_mode_enable_n),
    .dout(prog_s_n)
  );
  pss_sync u_sync_inh (
    .clk(clk),
    .rstn(rstn),
    .din(radio_inhibit_n),
    .dout(inhibit_s_n)
  );
  pss_sync u_sync_doze (
    .clk(clk),
    .rstn(rstn),
    .din(forced_doze_n),
    .dout(doze_s_n)
  );
  pss_sync u_sync_time (
    .clk(clk),
    .rstn(rstn),
    .din(time_capture_request_n),
    .dout(time_s_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic pss_pkg::pss_power_s power_for(input pss_pkg::pss_state_e s,
                                                    input logic cpu, input logic per);
    pss_pkg::pss_power_s p;
    p = '0;
    p.slow_osc_en = 1'b1;
    p.slow_timer_en = 1'b1;
    p.state_retain = 1'b1;
    case (s)
      pss_pkg::PSS_ACTIVE, pss_pkg::PSS_RFCHECK, pss_pkg::PSS_BOOT,
      pss_pkg::PSS_LOAD, pss_pkg::PSS_FLASHEM: begin
        p.relax_osc_en = 1'b1;
        p.periph_en = per | (s != pss_pkg::PSS_ACTIVE);
        p.cpu_run = cpu & (s == pss_pkg::PSS_ACTIVE);
      end
      pss_pkg::PSS_LOWPWR: begin
        p.slow_timer_en = 1'b0;
        p.state_retain = 1'b0;
      end
      default: begin
        p.relax_osc_en = 1'b0;
      end
    endcase
    return p;
  endfunction

  // Start of a boot page load, from power-on or from a reset pin fall
  function automatic pss_regs_s start_load(input pss_regs_s r);
    pss_regs_s n;
    n = r;
    n.st = pss_pkg::PSS_LOAD;
    n.addr = '0;
    n.rd = 1'b1;
    n.rd_pend = 1'b1;
    return n;
  endfunction

  // Start of the boot sequence, from the pin check or the low energy wait
  function automatic pss_regs_s start_boot(input pss_regs_s r);
    pss_regs_s n;
    n = r;
    n.st = pss_pkg::PSS_BOOT;
    n.cnt = pss_pkg::CNT_ZERO;
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic rst_fall;
  logic rst_asserted;
  logic prog_asserted;
  logic doze_forced;
  logic wake_io;
  logic idle;

  always_comb begin
    st_nxt = st_r;
    rst_asserted = !rst_s_n;
    prog_asserted = !prog_s_n;
    doze_forced = !doze_s_n;
    rst_fall = rst_asserted && !st_r.rst_d;
    wake_io = !time_s_n || uart_activity || activity.io_wake || activity.timer_wake;
    idle = !activity.cpu_busy && !activity.periph_busy;
    st_nxt.rst_d = rst_asserted;
    st_nxt.rd = 1'b0;
    st_nxt.cpu_wake = 1'b0;

    // Radio gate: busy ops complete, new starts refused while inhibited
    st_nxt.radio_active = radio_in.busy;
    if (!inhibit_s_n && !st_r.radio_active && !radio_in.busy) begin
      st_nxt.inhibited = 1'b1;
    end else if (inhibit_s_n) begin
      st_nxt.inhibited = 1'b0;
    end
    st_nxt.grant = radio_in.start_req && inhibit_s_n && !st_r.inhibited
                   && st_r.operational && (st_r.st != pss_pkg::PSS_DOZE);

    case (st_r.st)
      pss_pkg::PSS_POR: begin
        if (st_r.cnt != pss_pkg::POR_LAST) begin
          st_nxt.cnt = st_r.cnt + 8'h01;
        end else if (por_done) begin
          st_nxt = start_load(st_nxt);
        end
      end
      pss_pkg::PSS_LOAD: begin
        // One word per two cycles: issue read, capture next cycle
        if (st_r.rd_pend && !st_r.rd) begin
          if (st_r.addr == pss_pkg::BOOT_IO_DIR_ADDR) begin
            st_nxt.io_dir = boot_rdata;
          end else if (st_r.addr > pss_pkg::BOOT_HW_LAST_ADDR) begin
            st_nxt.design_cfg = st_r.design_cfg ^ boot_rdata;
          end
          if (st_r.addr == pss_pkg::BOOT_LAST_ADDR) begin
            st_nxt.rd_pend = 1'b0;
            st_nxt.st = pss_pkg::PSS_CHECK;
          end else begin
            st_nxt.addr = st_r.addr + 9'h001;
            st_nxt.rd = 1'b1;
          end
        end
      end
      pss_pkg::PSS_CHECK: begin
        if (rst_asserted && prog_asserted) begin
          st_nxt.st = pss_pkg::PSS_FLASHEM;
        end else if (rst_asserted) begin
          st_nxt.st = pss_pkg::PSS_LOWPWR;
        end else begin
          st_nxt = start_boot(st_nxt);
        end
      end
      pss_pkg::PSS_FLASHEM: begin
        // SPI side of the emulated flash lives outside; this only holds the mode
        if (!rst_asserted || !prog_asserted) begin
          st_nxt.st = pss_pkg::PSS_CHECK;
        end
      end
      pss_pkg::PSS_LOWPWR: begin
        if (prog_asserted) begin
          st_nxt.st = pss_pkg::PSS_FLASHEM;
        end else if (!rst_asserted) begin
          st_nxt = start_boot(st_nxt);
        end
      end
      pss_pkg::PSS_BOOT: begin
        if (st_r.cnt == pss_pkg::BOOT_SEQ_LAST) begin
          st_nxt.st = pss_pkg::PSS_ACTIVE;
        end else begin
          st_nxt.cnt = st_r.cnt + 8'h01;
        end
      end
      pss_pkg::PSS_ACTIVE: begin
        if (doze_forced) begin
          st_nxt.st = pss_pkg::PSS_DOZE;
        end else if (idle && duty_cycle_en) begin
          st_nxt.st = pss_pkg::PSS_DOZE;
        end
      end
      pss_pkg::PSS_DOZE: begin
        if (doze_forced) begin
          st_nxt.st = pss_pkg::PSS_DOZE;
        end else if (wake_io || !duty_cycle_en) begin
          st_nxt.st = pss_pkg::PSS_ACTIVE;
          st_nxt.cpu_wake = 1'b1;
        end else if (rf_check_due) begin
          st_nxt.st = pss_pkg::PSS_RFCHECK;
        end
      end
      pss_pkg::PSS_RFCHECK: begin
        if (doze_forced) begin
          st_nxt.st = pss_pkg::PSS_DOZE;
        end else if (activity.packet_detected) begin
          st_nxt.st = pss_pkg::PSS_ACTIVE;
          st_nxt.cpu_wake = 1'b1;
        end else if (!activity.rf_energy) begin
          st_nxt.st = pss_pkg::PSS_DOZE;
        end
      end
      default: begin
        st_nxt.st = pss_pkg::PSS_POR;
      end
    endcase

    // Reset pin fall restarts start-up from any later state
    if (rst_fall && st_r.st != pss_pkg::PSS_POR && st_r.st != pss_pkg::PSS_LOAD) begin
      st_nxt = start_load(st_nxt);
      st_nxt.io_dir = pss_pkg::IO_DIR_RESET;
      st_nxt.design_cfg = '0;
      st_nxt.cpu_wake = 1'b0;
    end

    st_nxt.flash_emul = (st_nxt.st == pss_pkg::PSS_FLASHEM);
    st_nxt.min_energy = (st_nxt.st == pss_pkg::PSS_LOWPWR);
    st_nxt.operational = (st_nxt.st == pss_pkg::PSS_ACTIVE) ||
                         (st_nxt.st == pss_pkg::PSS_DOZE) ||
                         (st_nxt.st == pss_pkg::PSS_RFCHECK);
    st_nxt.power = power_for(st_nxt.st, activity.cpu_busy || st_nxt.cpu_wake,
                             activity.periph_busy);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.st <= pss_pkg::PSS_POR;
      st_r.io_dir <= pss_pkg::IO_DIR_RESET;
      st_r.power.slow_osc_en <= 1'b1;
      st_r.power.slow_timer_en <= 1'b1;
      st_r.power.relax_osc_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign boot_addr = st_r.addr;
  assign boot_rd = st_r.rd;
  assign io_dir = st_r.io_dir;
  assign design_cfg = st_r.design_cfg;
  assign flash_emul_en = st_r.flash_emul;
  assign min_energy = st_r.min_energy;
  assign radio_start_grant = st_r.grant;
  assign radio_inhibited = st_r.inhibited;
  assign cpu_wake = st_r.cpu_wake;
  assign operational = st_r.operational;
  assign power = st_r.power;
  assign state = st_r.st;

endmodule

// [rtl/pss_sync.sv]
`timescale 1ns/1ps
module pss_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic meta;
    logic sync;
  } pss_sync_s;

  pss_sync_s st_r;
  pss_sync_s st_nxt;

  always_comb begin
    st_nxt.meta = din;
    st_nxt.sync = st_r.meta;
  end

  // Idle level is high: every synchronised pin is active low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= 2'h3;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.sync;

endmodule

// [sim/pss_companion.sv]
`timescale 1ns/1ps
module pss_companion (
  input wire logic [3:0] cmd,
  output logic reset_pin_n,
  output logic program_mode_enable_n,
  output logic radio_inhibit_n,
  output logic forced_doze_n
);
  assign reset_pin_n = !cmd[3];
  assign program_mode_enable_n = !cmd[2];
  assign radio_inhibit_n = !cmd[1];
  assign forced_doze_n = !cmd[0];
endmodule

// [sim/pss_sequencer_checker.sv]
`timescale 1ns/1ps
module pss_sequencer_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic forced_doze_n,
  input wire pss_pkg::pss_activity_s activity,
  input wire pss_pkg::pss_radio_in_s radio_in,
  input wire logic flash_emul_en,
  input wire logic min_energy,
  input wire logic radio_start_grant,
  input wire logic radio_inhibited,
  input wire logic cpu_wake,
  input wire pss_pkg::pss_power_s power,
  input wire pss_pkg::pss_state_e state
);
  logic idle;
  logic in_act;
  assign idle = !activity.cpu_busy && !activity.periph_busy;
  assign in_act = state == pss_pkg::PSS_ACTIVE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_forced4; (!forced_doze_n) [*4]; endsequence
  sequence s_dozed; state == pss_pkg::PSS_DOZE; endsequence
  sequence s_boot_start; $rose(state == pss_pkg::PSS_BOOT); endsequence
  AST_FORCED_HOLD: assert property (s_forced4 ##0 s_dozed |=> s_dozed)
    else $error("forced doze left");
  AST_NO_GRANT: assert property (radio_inhibited && $past(radio_inhibited) |-> !radio_start_grant)
    else $error("grant while inhibited");
  AST_LET_FINISH: assert property ($rose(radio_inhibited) |-> !$past(radio_in.busy))
    else $error("inhibit cut running op");
  AST_EMUL_ON: assert property ($rose(state == pss_pkg::PSS_FLASHEM) |-> ##[0:1] flash_emul_en)
    else $error("emulation flag missing");
  AST_LOW_ENERGY: assert property (state == pss_pkg::PSS_LOWPWR [*2] |-> min_energy)
    else $error("min energy missing");
  AST_BOOT_ACTIVE: assert property (s_boot_start |-> ##[15:17] in_act)
    else $error("boot did not reach active");
  AST_DOZE_IDLE: assert property ($rose(state == pss_pkg::PSS_DOZE) && $past(in_act) &&
    $past(forced_doze_n, 2) && $past(forced_doze_n, 3) |-> $past(idle))
    else $error("doze while busy");
  AST_DOZE_CLOCKS: assert property (s_dozed [*2] |->
    power.slow_osc_en && power.slow_timer_en && power.state_retain)
    else $error("doze power wrong");
  AST_WAKE_PULSE: assert property (cpu_wake |=> !cpu_wake)
    else $error("wake pulse too long");
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [2:0] sel; logic [31:0] val;} pss_note_s;
  logic clk, rstn, por_done, uart_activity, duty_cycle_en, rf_check_due, woke, time_n;
  logic reset_pin_n, program_mode_enable_n, radio_inhibit_n, forced_doze_n;
  logic boot_rd, flash_emul_en, min_energy, radio_start_grant, radio_inhibited;
  logic cpu_wake, operational;
  logic [3:0] cmd;
  logic [8:0] boot_addr;
  logic [31:0] boot_rdata, io_dir, design_cfg, exp_cfg;
  logic [31:0] mem [512];
  pss_pkg::pss_activity_s activity;
  pss_pkg::pss_radio_in_s radio_in;
  pss_pkg::pss_power_s power;
  pss_pkg::pss_state_e state;
  pss_note_s q[$];
  pss_note_s n;
  int errors = 0, checks = 0, seed = 32'hAFCB;
  event ev;
  pss_companion PARTNER (.cmd, .reset_pin_n, .program_mode_enable_n, .radio_inhibit_n,
    .forced_doze_n);
  pss_sequencer DUT (.clk, .rstn, .por_done, .reset_pin_n, .program_mode_enable_n,
    .radio_inhibit_n, .forced_doze_n, .time_capture_request_n(time_n), .uart_activity,
    .duty_cycle_en, .rf_check_due, .activity, .radio_in, .boot_rdata, .boot_addr, .boot_rd,
    .io_dir, .design_cfg, .flash_emul_en, .min_energy, .radio_start_grant, .radio_inhibited,
    .cpu_wake, .operational, .power, .state);
  ////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] pick(input logic [2:0] s);
    case (s)
      3'h0: return 32'(state);
      3'h1: return io_dir;
      3'h2: return design_cfg;
      3'h3: return {28'h0, radio_start_grant, radio_inhibited, flash_emul_en, min_energy};
      default: return {31'h0, woke};
    endcase
  endfunction
  task automatic note(input logic [2:0] s, input logic [31:0] v);
    q.push_back({s, v});
    ->ev;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_st(input pss_pkg::pss_state_e s);
    for (int i = 0; i < 3000 && state !== s; i++) @(posedge clk) #1;
    note(3'h0, 32'(s));
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    finish_test;
  end
  // Flash answers a cycle after the strobe, otherwise shows a moving pattern
  always @(posedge clk) boot_rdata <= #1 boot_rd ? mem[boot_addr] : ~boot_rdata;
  // Latched as the pulse appears, so it is seen in the cycle the wake lands
  always @(posedge cpu_wake) woke <= 1'b1;
  initial forever begin
    @ev;
    while (q.size() > 0) begin
      n = q.pop_front();
      check(pick(n.sel), n.val);
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    rstn = 0; por_done = 1; cmd = '0; uart_activity = 0; duty_cycle_en = 0;
    rf_check_due = 0; activity = '0; radio_in = '0; woke = 0; boot_rdata = '0; exp_cfg = '0;
    time_n = 1;
    for (int i = 0; i < 512; i++) begin
      mem[i] = $random(seed);
      if (i >= 256) exp_cfg ^= mem[i];
    end
    activity.cpu_busy = 1;
    cyc(5);
    rstn = 1;
    wait_st(pss_pkg::PSS_ACTIVE);
    note(3'h1, mem[0]);
    note(3'h2, exp_cfg);
    radio_in.start_req = 1; cyc(2); note(3'h3, 32'h8);
    radio_in.busy = 1; cmd[1] = 1; cyc(6); note(3'h3, 32'h0);
    radio_in.busy = 0; cyc(2); note(3'h3, 32'h4);
    cmd[1] = 0; cyc(5); note(3'h3, 32'h8);
    radio_in.start_req = 0; cmd[0] = 1;
    wait_st(pss_pkg::PSS_DOZE);
    uart_activity = 1; cyc(10); note(3'h0, 32'(pss_pkg::PSS_DOZE));
    woke = 0; cmd[0] = 0;
    wait_st(pss_pkg::PSS_ACTIVE); note(3'h4, 32'h1);
    uart_activity = 0; duty_cycle_en = 1; activity.cpu_busy = 0;
    wait_st(pss_pkg::PSS_DOZE);
    woke = 0; time_n = 0;
    wait_st(pss_pkg::PSS_ACTIVE); note(3'h4, 32'h1);
    time_n = 1; cyc(4);
    wait_st(pss_pkg::PSS_DOZE);
    woke = 0; activity.rf_energy = 1; rf_check_due = 1;
    wait_st(pss_pkg::PSS_RFCHECK);
    rf_check_due = 0; activity.rf_energy = 0;
    wait_st(pss_pkg::PSS_DOZE); note(3'h4, 32'h0);
    activity = 6'h23; rf_check_due = 1;
    wait_st(pss_pkg::PSS_ACTIVE); note(3'h4, 32'h1);
    rf_check_due = 0; activity = 6'h20; duty_cycle_en = 0; cmd[3:2] = 2'h3;
    wait_st(pss_pkg::PSS_FLASHEM); note(3'h3, 32'h2);
    cmd[2] = 0;
    wait_st(pss_pkg::PSS_LOWPWR); note(3'h3, 32'h1);
    cmd[3] = 0;
    wait_st(pss_pkg::PSS_ACTIVE);
    cyc(2);
    finish_test;
  end
endmodule
bind pss_sequencer pss_sequencer_checker CHK (.clk, .rstn, .forced_doze_n, .activity,
  .radio_in, .flash_emul_en, .min_energy, .radio_start_grant, .radio_inhibited, .cpu_wake,
  .power, .state);
